/* File: afesp_top.sv */
// afesp_top.sv: serial port, master reset and clock tree of a three-channel converter front end
// assumes: every pin input is asynchronous to i_sys_clk and far slower than it (link clock 125 ns);
// configuration inputs and i_read_word come from logic on i_sys_clk
`timescale 1ns/100ps
`include "afesp_defines.svh"

// Behaviour
// - output bits change on serial clock falling
// - output floats during the command byte
// - output floats on writes, deselect, reset
// - output driven only while servicing reads
// - input bits sampled on serial clock rising
// - chip select fall, then 8-bit command
// - input ignored after command or deselected
// - capture ratio pins on 2-wire entry, watchdog
// - master reset clears state, blocks serial port
// - reset stops internal clocks, equals power-on
// - converters and biases stay enabled
// - external_clock_select picks crystal or pin
// - prescale_select divides by 1, 2, 4, 8
// - sample_clock is analog clock over four
// - one ready strobe per output word
// - output rate is sample over ratio
// - strobe low for half sample period
// - chip select opens and closes transactions
module afesp_top #(
    parameter int CMD_BITS  = `AFESP_CMD_BITS,
    parameter int WORD_BITS = `AFESP_WORD_BITS
) (
    // system
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_rst_b,
    // serial port pins
    input  wire logic                       i_spi_cs_b,
    input  wire logic                       i_spi_sck,
    input  wire logic                       i_spi_sdi,
    output logic                            o_spi_sdo,
    output logic                            o_spi_sdo_oe,
    // master reset pin and clock pins
    input  wire logic                       i_master_reset_b,
    input  wire logic                       i_xtal_clk,
    input  wire logic                       i_external_clock_pin,
    // configuration
    input  wire logic                       i_external_clock_select,
    input  wire logic [1:0]                 i_prescale_select,
    input  wire logic [2:0]                 i_ratio_code,
    input  wire logic                       i_two_wire_mode,
    input  wire logic                       i_watchdog_reset,
    // register map side
    input  wire logic [WORD_BITS-1:0]       i_read_word,
    output logic [CMD_BITS-1:0]             o_cmd_byte,
    output logic                            o_cmd_valid,
    output logic                            o_cmd_is_read,
    output logic                            o_read_next,
    // clock tree and status
    output afesp_pkg::afesp_clk_t           o_clocks,
    output logic                            o_result_ready_strobe_b,
    output afesp_pkg::afesp_ratio_pins_t    o_ratio_pins,
    output logic                            o_converter_enable,
    output logic                            o_bias_enable,
    output logic                            o_in_master_reset
);

    localparam int CNT_BITS = $clog2(CMD_BITS);

    // shift logic assumes whole bytes
    if (CMD_BITS != 8 || WORD_BITS != 8) begin : g_check
        $error("afesp_top: CMD_BITS and WORD_BITS must be 8");
    end

    // ---------------- synchronisers ----------------
    logic [`AFESP_SYNC_LANES-1:0] pins_in;
    logic [`AFESP_SYNC_LANES-1:0] sync1_reg;
    logic [`AFESP_SYNC_LANES-1:0] sync2_reg;
    logic [`AFESP_SYNC_LANES-1:0] sync3_reg;

    // cs and reset pin idle high so they reset to one
    assign pins_in = {i_external_clock_pin, i_xtal_clk, i_master_reset_b, i_spi_sdi, i_spi_sck, i_spi_cs_b};

    for (genvar g = 0; g < `AFESP_SYNC_LANES; g++) begin : g_sync
        localparam logic RST_VAL = (g == 0 || g == 3) ? 1'b1 : 1'b0;
        always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                sync1_reg[g] <= RST_VAL;
                sync2_reg[g] <= RST_VAL;
                sync3_reg[g] <= RST_VAL;
            end else begin
                sync1_reg[g] <= pins_in[g];
                sync2_reg[g] <= sync1_reg[g];
                sync3_reg[g] <= sync2_reg[g];
            end
        end
    end

    wire cs_s       = sync2_reg[0];
    wire sck_s      = sync2_reg[1];
    wire sdi_s      = sync2_reg[2];
    wire rstpin_s   = sync2_reg[3];
    wire sck_rise   = sck_s & ~sync3_reg[1];
    wire sck_fall   = ~sck_s & sync3_reg[1];
    wire cs_fall    = ~cs_s & sync3_reg[0];

    // master reset only acts in SPI mode; in 2-wire mode the pin is a ratio select
    wire hard_rst   = ~i_two_wire_mode & ~rstpin_s;

    // ---------------- main clock selection ----------------
    wire mclk_lvl   = i_external_clock_select ? sync2_reg[5] : sync2_reg[4];
    wire mclk_prev  = i_external_clock_select ? sync3_reg[5] : sync3_reg[4];
    // a switch of the select can fake one edge; the divider simply absorbs it
    wire mclk_tick  = mclk_lvl & ~mclk_prev & ~hard_rst;

    // ---------------- dividers ----------------
    logic [`AFESP_PRE_CNT_BITS-1:0] pre_cnt_reg;
    logic [`AFESP_QUARTER_BITS-1:0] quarter_cnt_reg;
    logic [`AFESP_OSR_CNT_BITS-1:0] osr_cnt_reg;

    wire [`AFESP_PRE_CNT_BITS-1:0] pre_mask = `AFESP_PRE_FULL_MASK >> (`AFESP_PRE_MAX - i_prescale_select);
    wire [`AFESP_OSR_CNT_BITS-1:0] osr_mask = `AFESP_OSR_FULL_MASK >> (`AFESP_RATIO_MAX - i_ratio_code);
    wire analog_domain_clock_tick  = mclk_tick & ((pre_cnt_reg & pre_mask) == pre_mask);
    wire sample_tick = analog_domain_clock_tick & (quarter_cnt_reg == `AFESP_QUARTER_LAST);
    wire rate_tick   = sample_tick & ((osr_cnt_reg & osr_mask) == osr_mask);

    wire [`AFESP_PRE_CNT_BITS-1:0] pre_cnt_next = hard_rst ? '0
                                                : mclk_tick ? pre_cnt_reg + 1'b1 : pre_cnt_reg;
    wire [`AFESP_QUARTER_BITS-1:0] quarter_next = hard_rst ? '0
                                                : analog_domain_clock_tick ? quarter_cnt_reg + 1'b1 : quarter_cnt_reg;
    wire [`AFESP_OSR_CNT_BITS-1:0] osr_cnt_next = hard_rst ? '0
                                                : sample_tick ? osr_cnt_reg + 1'b1 : osr_cnt_reg;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pre_cnt_reg     <= '0;
            quarter_cnt_reg <= '0;
            osr_cnt_reg     <= '0;
        end else begin
            pre_cnt_reg     <= pre_cnt_next;
            quarter_cnt_reg <= quarter_next;
            osr_cnt_reg     <= osr_cnt_next;
        end
    end

    // derived clock levels; by-one prescale follows the main clock itself
    wire [1:0] pre_idx    = i_prescale_select - 2'h1;
    wire [3:0] rate_idx   = {1'b0, i_ratio_code} + {1'b0, `AFESP_OSR_LOG_BASE};
    wire analog_domain_clock_lvl        = (i_prescale_select == 2'h0) ? mclk_lvl : pre_cnt_reg[pre_idx];
    afesp_pkg::afesp_clk_t clocks_next;
    always_comb begin
        clocks_next.analog_domain_clock = hard_rst ? 1'b0 : analog_domain_clock_lvl;
        clocks_next.sample_clock        = hard_rst ? 1'b0 : quarter_cnt_reg[1];
        clocks_next.output_rate_clock   = hard_rst ? 1'b0 : osr_cnt_reg[rate_idx];
    end

    // ---------------- result ready strobe ----------------
    // low from the word boundary until half the sample period has passed
    logic strobe_b_reg;
    wire  strobe_end    = analog_domain_clock_tick & (quarter_cnt_reg == `AFESP_STROBE_END);
    wire  strobe_b_next = hard_rst ? 1'b1
                        : rate_tick ? 1'b0
                        : strobe_end ? 1'b1 : strobe_b_reg;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            strobe_b_reg <= 1'b1;
            o_clocks     <= '0;
        end else begin
            strobe_b_reg <= strobe_b_next;
            o_clocks     <= clocks_next;
        end
    end

    assign o_result_ready_strobe_b = strobe_b_reg;

    // ---------------- 2-wire ratio pin capture ----------------
    logic mode_prev_reg;
    wire  capture_pins = (i_two_wire_mode & ~mode_prev_reg) | i_watchdog_reset;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_prev_reg <= 1'b0;
            o_ratio_pins  <= '0;
        end else begin
            mode_prev_reg <= i_two_wire_mode;
            if (capture_pins) begin
                o_ratio_pins.ratio_select_hi_pin <= sdi_s;
                o_ratio_pins.ratio_select_lo_pin <= rstpin_s;
            end
        end
    end

    // ---------------- serial port ----------------
    afesp_pkg::afesp_state_t   state_reg;
    afesp_pkg::afesp_state_t   state_next;
    logic [CNT_BITS-1:0]       bit_cnt_reg;
    logic [CNT_BITS-1:0]       bit_cnt_next;
    logic [CMD_BITS-1:0]       cmd_reg;
    logic [CMD_BITS-1:0]       cmd_next;
    logic [WORD_BITS-1:0]      tx_reg;
    logic [WORD_BITS-1:0]      tx_next;
    logic                      sdo_next;
    logic                      cmd_valid_next;
    logic                      is_read_next;
    logic                      read_next_next;

    wire last_bit             = (bit_cnt_reg == CNT_BITS'(CMD_BITS - 1));
    wire [CMD_BITS-1:0] cmd_shift = {cmd_reg[CMD_BITS-2:0], sdi_s};
    wire byte_start           = (bit_cnt_reg == '0);
    wire [WORD_BITS-1:0] tx_src = byte_start ? i_read_word : tx_reg;

    always_comb begin
        state_next     = state_reg;
        bit_cnt_next   = bit_cnt_reg;
        cmd_next       = cmd_reg;
        tx_next        = tx_reg;
        sdo_next       = o_spi_sdo;
        cmd_valid_next = 1'b0;
        is_read_next   = o_cmd_is_read;
        read_next_next = 1'b0;
        if (hard_rst || cs_s) begin
            // deselect closes the transaction; reset refuses it outright
            state_next   = afesp_pkg::AFESP_IDLE;
            bit_cnt_next = '0;
            sdo_next     = 1'b0;
            if (hard_rst) begin
                cmd_next     = '0;
                is_read_next = 1'b0;
            end
        end else begin
            case (state_reg)
                afesp_pkg::AFESP_IDLE: begin
                    // only a fresh falling edge opens a frame
                    if (cs_fall) begin
                        state_next   = afesp_pkg::AFESP_CMD;
                        bit_cnt_next = '0;
                    end
                end
                afesp_pkg::AFESP_CMD: begin
                    if (sck_rise) begin
                        cmd_next     = cmd_shift;
                        bit_cnt_next = bit_cnt_reg + 1'b1;
                        if (last_bit) begin
                            cmd_valid_next = 1'b1;
                            bit_cnt_next   = '0;
                            is_read_next   = (cmd_shift[`AFESP_CMD_READ_BIT] == `AFESP_CMD_READ_VAL);
                            state_next     = is_read_next ? afesp_pkg::AFESP_READ
                                                          : afesp_pkg::AFESP_WRITE;
                        end
                    end
                end
                afesp_pkg::AFESP_READ: begin
                    // input bits and rising clock edges are not looked at here
                    if (sck_fall) begin
                        sdo_next       = tx_src[WORD_BITS-1];
                        tx_next        = {tx_src[WORD_BITS-2:0], 1'b0};
                        read_next_next = byte_start;
                        bit_cnt_next   = bit_cnt_reg + 1'b1;
                    end
                end
                default: begin
                    // write frames drop all further input
                    state_next = afesp_pkg::AFESP_WRITE;
                end
            endcase
        end
    end

    // drive only in the read phase of a selected, unreset frame
    wire sdo_oe_next = (state_next == afesp_pkg::AFESP_READ);

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg   <= afesp_pkg::AFESP_IDLE;
            bit_cnt_reg <= '0;
            cmd_reg     <= '0;
            tx_reg      <= '0;
        end else begin
            state_reg   <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            cmd_reg     <= cmd_next;
            tx_reg      <= tx_next;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_spi_sdo     <= 1'b0;
            o_spi_sdo_oe  <= 1'b0;
            o_cmd_byte    <= '0;
            o_cmd_valid   <= 1'b0;
            o_cmd_is_read <= 1'b0;
            o_read_next   <= 1'b0;
        end else begin
            o_spi_sdo     <= sdo_next;
            o_spi_sdo_oe  <= sdo_oe_next;
            o_cmd_byte    <= cmd_next;
            o_cmd_valid   <= cmd_valid_next;
            o_cmd_is_read <= is_read_next;
            o_read_next   <= read_next_next;
        end
    end

    // ---------------- status ----------------
    // converters and biases are never dropped by the master reset
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_converter_enable <= 1'b1;
            o_bias_enable      <= 1'b1;
            o_in_master_reset  <= 1'b0;
        end else begin
            o_converter_enable <= 1'b1;
            o_bias_enable      <= 1'b1;
            o_in_master_reset  <= hard_rst;
        end
    end

endmodule // afesp_top

/* File: afesp_defines.svh */
// afesp_defines.svh: constants of the converter front end serial port and clock tree
// assumes: included by bare name from the top module
`ifndef AFESP_DEFINES_SVH
`define AFESP_DEFINES_SVH

// command framing
`define AFESP_CMD_BITS        8
`define AFESP_WORD_BITS       8
`define AFESP_CMD_READ_BIT    0
`define AFESP_CMD_READ_VAL    1'h1

// clock tree
`define AFESP_PRE_DEFAULT     2'h0
`define AFESP_RATIO_DEFAULT   3'h3
`define AFESP_PRE_CNT_BITS    3
`define AFESP_QUARTER_BITS    2
`define AFESP_QUARTER_LAST    2'h3
`define AFESP_STROBE_END      2'h1
`define AFESP_OSR_CNT_BITS    12
`define AFESP_OSR_LOG_BASE    3'h4
`define AFESP_OSR_FULL_MASK   12'hfff
`define AFESP_PRE_FULL_MASK   3'h7
`define AFESP_RATIO_MAX       3'h7
`define AFESP_PRE_MAX         2'h3

// synchroniser lanes
`define AFESP_SYNC_LANES      6

`endif

/* File: afesp_pkg.sv */
// afesp_pkg.sv: types shared by the converter front end interface logic
// assumes: afesp_defines.svh is on the include path
package afesp_pkg;

    // serial port phases
    typedef enum logic [1:0] {
        AFESP_IDLE,
        AFESP_CMD,
        AFESP_READ,
        AFESP_WRITE
    } afesp_state_t;

    // derived clock levels, sampled in the system clock domain
    typedef struct packed {
        logic analog_domain_clock;
        logic sample_clock;
        logic output_rate_clock;
    } afesp_clk_t;

    // levels captured for the 2-wire interface
    typedef struct packed {
        logic ratio_select_hi_pin;
        logic ratio_select_lo_pin;
    } afesp_ratio_pins_t;

endpackage

/* File: afesp_host_model.sv */
// afesp_host_model.sv: serial bus master that drives chip select, clock and data in
// assumes: mode 0 timing, 125 ns clock period, pins asynchronous to the system clock
`timescale 1ns/100ps
module afesp_host_model (
    // pins toward the device
    output logic      o_cs_b,
    output logic      o_sck,
    output logic      o_sdi,
    // data out line as resolved by the bench
    input  wire logic i_sdo
);
    initial begin
        o_cs_b = 1'h1;
        o_sck  = 1'h0;
        o_sdi  = 1'h0;
    end

    // one frame: command byte, then one data byte, msb first; clock stands low outside frames
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wr, output logic [7:0] rd);
        logic [15:0] sh;
        sh     = {cmd, wr};
        rd     = 8'h00;
        o_cs_b = 1'h0;
        for (int i = 15; i >= 0; i--) begin
            o_sdi = sh[i];
            #62.5;
            o_sck = 1'h1;
            if (i < 8) rd[i] = i_sdo;
            #62.5;
            o_sck = 1'h0;
        end
        #62.5;
        o_cs_b = 1'h1;
        // toggle data in while deselected; the device must not notice
        o_sdi  = ~o_sdi;
    endtask
endmodule // afesp_host_model

/* File: afesp_top_chk.sv */
// afesp_top_chk.sv: concurrent checks on the serial port, master reset and clock tree
// assumes: bound into afesp_top; everything sampled on i_sys_clk
`timescale 1ns/100ps
module afesp_top_chk #(
    parameter int CMD_BITS  = 8,
    parameter int WORD_BITS = 8
) (
    // system
    input wire logic                  i_sys_clk,
    input wire logic                  i_rst_b,
    // pins
    input wire logic                  i_spi_cs_b,
    input wire logic                  i_spi_sck,
    input wire logic                  i_master_reset_b,
    input wire logic                  i_two_wire_mode,
    // outputs watched
    input wire logic                  o_spi_sdo,
    input wire logic                  o_spi_sdo_oe,
    input wire logic                  o_cmd_valid,
    input wire logic                  o_cmd_is_read,
    input wire logic                  o_read_next,
    input wire afesp_pkg::afesp_clk_t o_clocks,
    input wire logic                  o_result_ready_strobe_b,
    input wire logic                  o_converter_enable,
    input wire logic                  o_bias_enable,
    input wire logic                  o_in_master_reset
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);

    // margins of four or five cycles cover the two-flop pin synchronisers
    a_sdo_float_cs: assert property (i_spi_cs_b [*5] |-> !o_spi_sdo_oe)
        else $error("data out driven while deselected");
    a_sdo_float_rst: assert property ((!i_master_reset_b && !i_two_wire_mode) [*5] |-> !o_spi_sdo_oe && o_in_master_reset)
        else $error("master reset not honoured");
    a_oe_on_read: assert property ($rose(o_spi_sdo_oe) |-> o_cmd_valid && o_cmd_is_read)
        else $error("data out enabled outside a read");
    a_write_no_drive: assert property (o_cmd_valid && !o_cmd_is_read |-> !o_spi_sdo_oe [*8])
        else $error("data out driven in a write");
    a_sdo_on_fall: assert property ((i_spi_sck && o_spi_sdo_oe) [*4] |-> $stable(o_spi_sdo))
        else $error("data out moved while clock high");
    a_next_in_read: assert property (o_read_next |-> o_spi_sdo_oe && o_cmd_is_read)
        else $error("read word taken outside a read");
    a_cmd_in_frame: assert property (o_cmd_valid |-> !$past(i_spi_cs_b, 4) && !o_in_master_reset)
        else $error("command taken while deselected");
    a_clk_held: assert property (o_in_master_reset && $past(o_in_master_reset) |-> o_clocks == 3'h0 && o_result_ready_strobe_b)
        else $error("clocks run in master reset");
    a_analog_on: assert property (o_converter_enable && o_bias_enable)
        else $error("converter or bias disabled");
    a_valid_pulse: assert property (o_cmd_valid |=> !o_cmd_valid)
        else $error("command valid longer than a cycle");
endmodule // afesp_top_chk

bind afesp_top afesp_top_chk #(.CMD_BITS(CMD_BITS), .WORD_BITS(WORD_BITS)) u_chk (
    .i_sys_clk, .i_rst_b, .i_spi_cs_b, .i_spi_sck, .i_master_reset_b, .i_two_wire_mode,
    .o_spi_sdo, .o_spi_sdo_oe, .o_cmd_valid, .o_cmd_is_read, .o_read_next, .o_clocks,
    .o_result_ready_strobe_b, .o_converter_enable, .o_bias_enable, .o_in_master_reset);

/* File: tb.sv */
// tb.sv: self-checking bench for the serial port, master reset and clock tree
// assumes: design and host model compiled first; main clocks run at 32 ns, 4 system cycles
`timescale 1ns/100ps
module tb;
    logic                         i_sys_clk, i_rst_b, i_master_reset_b, i_xtal_clk;
    logic                         i_external_clock_pin, i_external_clock_select;
    logic                         i_two_wire_mode, i_watchdog_reset;
    logic [1:0]                   i_prescale_select;
    logic [2:0]                   i_ratio_code;
    logic [7:0]                   i_read_word, o_cmd_byte;
    logic                         i_spi_cs_b, i_spi_sck, i_spi_sdi, o_spi_sdo, o_spi_sdo_oe;
    logic                         o_cmd_valid, o_cmd_is_read, o_read_next, o_result_ready_strobe_b;
    logic                         o_converter_enable, o_bias_enable, o_in_master_reset;
    afesp_pkg::afesp_clk_t        o_clocks, c0, clk_q;
    afesp_pkg::afesp_ratio_pins_t o_ratio_pins;
    logic                         ext_run, flip;
    wire logic                    sdo_line;
    logic [31:0]                  seed;
    int                           err_total, checks_done, cycles, n_valid, n_next, n_oe, n_ac, n_sc, n_oc;

    // a released data line shows a pattern that changes every cycle, never a stale bit
    assign sdo_line = o_spi_sdo_oe ? o_spi_sdo : flip;

    afesp_top uut (.i_sys_clk, .i_rst_b, .i_spi_cs_b, .i_spi_sck, .i_spi_sdi, .o_spi_sdo, .o_spi_sdo_oe,
        .i_master_reset_b, .i_xtal_clk, .i_external_clock_pin, .i_external_clock_select, .i_prescale_select,
        .i_ratio_code, .i_two_wire_mode, .i_watchdog_reset, .i_read_word, .o_cmd_byte, .o_cmd_valid,
        .o_cmd_is_read, .o_read_next, .o_clocks, .o_result_ready_strobe_b, .o_ratio_pins,
        .o_converter_enable, .o_bias_enable, .o_in_master_reset);
    afesp_host_model host (.o_cs_b(i_spi_cs_b), .o_sck(i_spi_sck), .o_sdi(i_spi_sdi), .i_sdo(sdo_line));

    initial begin
        i_sys_clk = 1'h0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    // main clocks offset 2 ns from the system edges
    initial begin
        #2;
        forever begin
            #16;
            i_xtal_clk = ~i_xtal_clk;
            if (ext_run) i_external_clock_pin = ~i_external_clock_pin;
        end
    end

    always @(posedge i_sys_clk) begin
        flip    <= ~flip;
        cycles  <= cycles + 1;
        n_valid <= n_valid + int'(o_cmd_valid);
        n_next  <= n_next + int'(o_read_next);
        n_oe    <= n_oe + int'(o_spi_sdo_oe);
        // rising edges of the derived clock levels
        n_ac    <= n_ac + int'(o_clocks.analog_domain_clock & ~clk_q.analog_domain_clock);
        n_sc    <= n_sc + int'(o_clocks.sample_clock & ~clk_q.sample_clock);
        n_oc    <= n_oc + int'(o_clocks.output_rate_clock & ~clk_q.output_rate_clock);
        clk_q   <= o_clocks;
        // worst case clock tree waits take about two periods per setting
        if (cycles == 90000) begin
            err_total++;
            give_verdict();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // strobe period and low width in system cycles for a 4-cycle main clock
    function automatic int exp_period(int p, int r);
        return (16 << p) * (32 << r);
    endfunction
    function automatic int exp_width(int p);
        return 8 << p;
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic frame(input logic [7:0] cmd, input logic live);
        logic [7:0] rd;
        int         v0, x0, o0;
        tick(1);
        i_read_word = 8'(rnd());
        v0 = n_valid;
        x0 = n_next;
        o0 = n_oe;
        host.xfer(cmd, 8'(rnd()), rd);
        tick(6);
        check(32'(n_valid - v0), 32'(live));
        check(32'(o_cmd_byte), live ? 32'(cmd) : 32'h0);
        check(32'(o_spi_sdo_oe), 32'h0);
        if (live && cmd[0]) begin
            check(32'(rd), 32'(i_read_word));
            check(32'(n_next - x0), 32'h2);
            check(32'(o_cmd_is_read), 32'h1);
        end else begin
            check(32'(n_oe - o0), 32'h0);
        end
    endtask

    task automatic wait_lvl(input logic lvl, output int n);
        n = 0;
        while (o_result_ready_strobe_b !== lvl && n < 20000) begin
            tick(1);
            n++;
        end
    endtask
    // the first strobe after a change only realigns the counters, the next one is timed
    task automatic rate(input logic [1:0] p, input logic [2:0] r);
        int a, w, ac, sc, oc;
        i_prescale_select = p;
        i_ratio_code = r;
        wait_lvl(1'h1, a);
        wait_lvl(1'h0, a);
        wait_lvl(1'h1, a);
        {ac, sc, oc} = {n_ac, n_sc, n_oc};
        wait_lvl(1'h0, a);
        wait_lvl(1'h1, w);
        check(32'(a + w), 32'(exp_period(p, r)));
        check(32'(w), 32'(exp_width(p)));
        // one strobe period holds four analog edges per sample and one rate edge
        check(32'(n_ac - ac), 32'(128 << r));
        check(32'(n_sc - sc), 32'(32 << r));
        check(32'(n_oc - oc), 32'h1);
    endtask

    initial begin
        seed = 32'h00017d84;
        {err_total, checks_done, cycles, n_valid, n_next, n_oe, n_ac, n_sc, n_oc} = '0;
        {flip, i_xtal_clk, i_external_clock_pin, i_rst_b, i_two_wire_mode, i_watchdog_reset} = '0;
        {ext_run, i_master_reset_b, i_external_clock_select} = 3'h6;
        i_prescale_select = 2'h0;
        i_ratio_code = 3'h3;
        i_read_word = 8'h00;
        tick(6);
        i_rst_b = 1'h1;
        tick(2);
        check(32'(o_spi_sdo_oe), 32'h0);
        check(32'(o_cmd_byte), 32'h0);
        check(32'({o_in_master_reset, o_converter_enable, o_bias_enable}), 32'h3);
        $display("reset values done");
        frame(8'h00, 1'h1);
        frame(8'hff, 1'h1);
        frame(8'h01, 1'h1);
        for (int k = 0; k < 6; k++) frame(8'(rnd()), 1'h1);
        $display("frames done");
        i_master_reset_b = 1'h0;
        tick(8);
        check(32'(o_in_master_reset), 32'h1);
        check(32'({o_clocks, o_result_ready_strobe_b}), 32'h1);
        frame(8'h81, 1'h0);
        i_master_reset_b = 1'h1;
        tick(4);
        frame(8'h81, 1'h1);
        $display("master reset done");
        i_external_clock_select = 1'h1;
        ext_run = 1'h0;
        tick(8);
        c0 = o_clocks;
        tick(20);
        check(32'(o_clocks), 32'(c0));
        ext_run = 1'h1;
        for (int p = 0; p < 4; p++) rate(2'(p), 3'h0);
        i_external_clock_select = 1'h0;
        for (int r = 1; r < 5; r++) rate(2'h0, 3'(r));
        $display("clock tree done");
        host.o_sdi = 1'h1;
        i_master_reset_b = 1'h0;
        tick(6);
        i_two_wire_mode = 1'h1;
        tick(6);
        check(32'(o_ratio_pins), 32'h2);
        host.o_sdi = 1'h0;
        i_master_reset_b = 1'h1;
        tick(6);
        check(32'(o_ratio_pins), 32'h2);
        i_watchdog_reset = 1'h1;
        tick(2);
        i_watchdog_reset = 1'h0;
        tick(2);
        check(32'(o_ratio_pins), 32'h1);
        $display("two-wire capture done");
        give_verdict();
    end
endmodule // tb
